// File: hdl/pfm_top.sv
// pin function mux, strap capture and mode decode
// Behaviour
// - pci strap picks host port plus gpio 15..9, or pci on the shared pins
// - cell or pci core disabled by strap: its own pins are undriven
// - gpio 9..15 carry no function after reset until software enables them
// - pin 1 outputs core clock / 4 by default, or gpio 1 when enabled
// - pin 2 outputs core clock / 6 by default, or gpio 2 when enabled
// - pll select straps give multiplier 1, 6, 12 or 20
// - emulation pins 00 boundary scan, 01/10 reserved, 11 emulation
// - core runs freely under boundary scan or emulation setting
// - nmi raised only on a rising edge of its pin
// - gpio 4..7 enabled as inputs after reset
// - enabled interrupt pins 4..7 detect edges, polarity per pin
// - gpio 3 enabled as input after reset
// - gpio 0 input by default, or output, or gpio interrupt output
// - pin 8 is serial port 2 clock input by default, or gpio 8
// - host irq pin is output in host mode, frame pin in pci mode
// - gpio active only when enabled; direction 0 input, 1 output; pins 4..7 stay input either way
// - width strap 0 gives 16-bit host port, upper data undriven
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`default_nettype none
`include "pfm_map.svh"
module pfm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pfm_pkg::pfm_strap_t strap_pins,
    input wire logic nmi_pin,
    input wire logic [15:0] gpio_in,
    output logic [15:0] gpio_out,
    output logic [15:0] gpio_oe,
    input wire logic gp0_irq_src,
    output logic serial2_ext_clock_in,
    input wire logic [6:0] pci_gp_out,
    input wire logic [6:0] pci_gp_oe,
    output logic [6:0] pci_gp_in,
    input wire logic [31:0] hd_in,
    output pfm_pkg::pfm_drive32_t hd_drive,
    input wire pfm_pkg::pfm_drive32_t hpi_drive,
    output logic [31:0] hpi_d_in,
    input wire pfm_pkg::pfm_drive32_t pci_ad_drive,
    output logic [31:0] pci_ad_in,
    input wire logic [3:0] hctl_in,
    output logic [3:0] hctl_out,
    output logic [3:0] hctl_oe,
    output logic [1:0] host_register_select,
    output logic host_halfword_select,
    output logic host_read_write_select,
    input wire logic [3:0] pci_ctl_out,
    input wire logic [3:0] pci_ctl_oe,
    output logic [3:0] pci_ctl_in,
    input wire logic hirq_in,
    output logic hirq_out,
    output logic hirq_oe,
    input wire logic host_irq_out,
    input wire logic pci_frame_out,
    input wire logic pci_frame_oe,
    output logic pci_frame_in,
    input wire logic [7:0] cell_core_out,
    input wire logic [7:0] cell_core_oe,
    output logic [7:0] cell_pin_out,
    output logic [7:0] cell_pin_oe,
    input wire logic [1:0] pci_only_out,
    input wire logic [1:0] pci_only_oe,
    output logic [1:0] pci_only_pin_out,
    output logic [1:0] pci_only_pin_oe,
    output logic [4:0] pll_multiplier,
    output pfm_pkg::pfm_emu_t emu_mode,
    output logic cpu_free_run,
    output logic [3:0] external_irq_pin,
    output logic nmi_irq,
    output logic host_port_16bit,
    output logic pci_mode
);
    pfm_pkg::pfm_state_t s_q;
    pfm_pkg::pfm_state_t s_d;
    logic [15:0] gp_act;
    logic [15:0] gp_drv;
    logic [3:0] ext_lvl;
    logic [3:0] ext_hit;
    logic [7:0] rd_addr;
    logic rd_take;

    // next state: straps, registers, dividers, edge detectors
    always_comb begin
        s_d = s_q;
        rd_take = 1'b0;
        rd_addr = haddr[7:0];
        // straps caught on the first edge after reset release
        if (!s_q.captured) begin
            s_d.captured = 1'b1;
            s_d.strap = strap_pins;
        end
        // divider for the quarter rate clock
        if (s_q.qtr_cnt == `PFM_QTR_LAST) begin
            s_d.qtr_cnt = '0;
            s_d.qtr_clk = ~s_q.qtr_clk;
        end else begin
            s_d.qtr_cnt = s_q.qtr_cnt + 3'h1;
        end
        // divider for the sixth rate clock
        if (s_q.six_cnt == `PFM_SIX_LAST) begin
            s_d.six_cnt = '0;
            s_d.six_clk = ~s_q.six_clk;
        end else begin
            s_d.six_cnt = s_q.six_cnt + 3'h1;
        end
        // nmi fires on a rising edge only
        s_d.nmi_prev = nmi_pin;
        s_d.nmi_pulse = nmi_pin & ~s_q.nmi_prev;
        // external interrupt edges on pins 4..7
        s_d.ext_prev = ext_lvl;
        s_d.ext_pulse = ext_hit;
        // write data phase of a previous address phase
        s_d.wr_pend = 1'b0;
        if (s_q.wr_pend) begin
            unique case (s_q.wr_addr)
                `PFM_OFS_GP_EN: s_d.gp_en = hwdata[15:0];
                `PFM_OFS_GP_DIR: s_d.gp_dir = hwdata[15:0];
                `PFM_OFS_GP_OUT: s_d.gp_out = hwdata[15:0];
                `PFM_OFS_IRQ_CTL: s_d.irq_ctl = hwdata[8:0];
                default: ;
            endcase
        end
        // address phase
        if (hsel && hready && htrans == `PFM_HTRANS_NONSEQ) begin
            if (hwrite) begin
                s_d.wr_pend = 1'b1;
                s_d.wr_addr = haddr[7:0];
            end else begin
                rd_take = 1'b1;
            end
        end
        // read data sees any write landing in this same cycle
        if (rd_take) begin
            unique case (rd_addr)
                `PFM_OFS_GP_EN: s_d.rdata = {16'h0000, s_d.gp_en};
                `PFM_OFS_GP_DIR: s_d.rdata = {16'h0000, s_d.gp_dir};
                `PFM_OFS_GP_OUT: s_d.rdata = {16'h0000, s_d.gp_out};
                `PFM_OFS_GP_IN: s_d.rdata = {16'h0000, gpio_in & gp_act};
                `PFM_OFS_IRQ_CTL: s_d.rdata = {23'h000000, s_d.irq_ctl};
                `PFM_OFS_STRAP: s_d.rdata = {25'h0000000, s_q.strap};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // per pin enable and drive for the general purpose pins
    always_comb begin
        gp_act = s_q.gp_en;
        // gpio 9..15 only exist while pci is off
        if (s_q.strap.pci_en) begin
            gp_act[`PFM_PCI_GP] = 7'h00;
        end
        gp_drv = gp_act & s_q.gp_dir;
        ext_lvl = gpio_in[`PFM_EXT_PINS] ^ s_q.irq_ctl[`PFM_IRQ_POL];
        // polarity 0 rising, 1 falling; enabled pins 4..7 only
        ext_hit = ext_lvl & ~s_q.ext_prev & s_q.irq_ctl[`PFM_IRQ_IEN]
            & gp_act[`PFM_EXT_PINS] & ~s_q.gp_dir[`PFM_EXT_PINS];
    end

    // state register, reset loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.gp_en <= `PFM_GP_EN_RST;
            s_q.gp_dir <= `PFM_GP_DIR_RST;
            s_q.gp_out <= `PFM_GP_OUT_RST;
            s_q.irq_ctl <= `PFM_IRQ_CTL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // bus answers: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;

    // gpio pin drive with clock outputs on pins 1 and 2
    always_comb begin
        gpio_out = s_q.gp_out;
        gpio_oe = gp_drv;
        if (!gp_act[`PFM_PIN_QTR]) begin
            gpio_out[`PFM_PIN_QTR] = s_q.qtr_clk;
            gpio_oe[`PFM_PIN_QTR] = 1'b1;
        end
        if (!gp_act[`PFM_PIN_SIX]) begin
            gpio_out[`PFM_PIN_SIX] = s_q.six_clk;
            gpio_oe[`PFM_PIN_SIX] = 1'b1;
        end
        // pin 0 as output may carry the interrupt signal instead
        if (s_q.irq_ctl[`PFM_IRQ_GP0]) begin
            gpio_out[`PFM_PIN_GP0] = gp0_irq_src;
        end
        // gpio 4..7 are input only
        gpio_oe[`PFM_EXT_PINS] = 4'h0;
        // pci owns pins 9..15 in pci mode
        if (s_q.strap.pci_en) begin
            gpio_out[`PFM_PCI_GP] = pci_gp_out;
            gpio_oe[`PFM_PCI_GP] = pci_gp_oe;
        end
    end

    // serial port 2 clock comes from pin 8 unless it is a gpio
    assign serial2_ext_clock_in =
        gp_act[`PFM_PIN_SER2] ? 1'b0 : gpio_in[`PFM_PIN_SER2];
    assign pci_gp_in = s_q.strap.pci_en ? gpio_in[`PFM_PCI_GP] : 7'h00;

    // shared data bus: host port or pci address/data
    always_comb begin
        if (s_q.strap.pci_en) begin
            hd_drive = pci_ad_drive;
        end else begin
            hd_drive = hpi_drive;
            // 16-bit host port leaves the upper lane undriven
            if (!s_q.strap.host_width) begin
                hd_drive.d_oe[`PFM_HD_UPPER] = 16'h0000;
            end
        end
    end
    assign hpi_d_in = s_q.strap.pci_en ? 32'h00000000 : hd_in;
    assign pci_ad_in = s_q.strap.pci_en ? hd_in : 32'h00000000;

    // host control pins are inputs in host mode
    always_comb begin
        hctl_out = pci_ctl_out;
        hctl_oe = s_q.strap.pci_en ? pci_ctl_oe : 4'h0;
        pci_ctl_in = s_q.strap.pci_en ? hctl_in : 4'h0;
        host_register_select = s_q.strap.pci_en ? 2'h0 : hctl_in[1:0];
        host_read_write_select = ~s_q.strap.pci_en & hctl_in[3];
        // halfword select only means something in 16-bit mode
        host_halfword_select = ~s_q.strap.pci_en & ~s_q.strap.host_width
            & hctl_in[2];
    end

    // host irq pin: output to host, or pci frame
    always_comb begin
        if (s_q.strap.pci_en) begin
            hirq_out = pci_frame_out;
            hirq_oe = pci_frame_oe;
        end else begin
            hirq_out = host_irq_out;
            hirq_oe = 1'b1;
        end
    end
    assign pci_frame_in = s_q.strap.pci_en & hirq_in;

    // pins owned by a single core go undriven when it is off
    assign cell_pin_out = s_q.strap.cell_en ? cell_core_out : 8'h00;
    assign cell_pin_oe = s_q.strap.cell_en ? cell_core_oe : 8'h00;
    assign pci_only_pin_out = s_q.strap.pci_en ? pci_only_out : 2'h0;
    assign pci_only_pin_oe =
        s_q.strap.pci_en ? pci_only_oe : 2'h0;

    // pll multiplier from the clock mode straps
    always_comb begin
        unique case (s_q.strap.pll_sel)
            2'h0: pll_multiplier = `PFM_MUL_X1;
            2'h1: pll_multiplier = `PFM_MUL_X6;
            2'h2: pll_multiplier = `PFM_MUL_X12;
            2'h3: pll_multiplier = `PFM_MUL_X20;
        endcase
    end

    // emulation pin decode
    always_comb begin
        unique case (s_q.strap.emu)
            `PFM_EMU_CODE_BSCAN: emu_mode = pfm_pkg::PFM_EMU_BSCAN;
            `PFM_EMU_CODE_EMUL: emu_mode = pfm_pkg::PFM_EMU_EMUL;
            default: emu_mode = pfm_pkg::PFM_EMU_RESERVED;
        endcase
    end
    assign cpu_free_run = s_q.captured
        && emu_mode != pfm_pkg::PFM_EMU_RESERVED;

    // event pulses and mode flags
    assign external_irq_pin = s_q.ext_pulse;
    assign nmi_irq = s_q.nmi_pulse;
    assign host_port_16bit = ~s_q.strap.pci_en & ~s_q.strap.host_width;
    assign pci_mode = s_q.strap.pci_en;
endmodule // pfm_top
`default_nettype wire

// File: hdl/pfm_map.svh
// register offsets, reset values, field positions and counts for pfm
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH
`define PFM_OFS_GP_EN 8'h00
`define PFM_OFS_GP_DIR 8'h04
`define PFM_OFS_GP_OUT 8'h08
`define PFM_OFS_GP_IN 8'h0C
`define PFM_OFS_IRQ_CTL 8'h10
`define PFM_OFS_STRAP 8'h14
`define PFM_GP_EN_RST 16'h00F9
`define PFM_GP_DIR_RST 16'h0000
`define PFM_GP_OUT_RST 16'h0000
`define PFM_IRQ_CTL_RST 9'h000
`define PFM_IRQ_POL 3:0
`define PFM_IRQ_IEN 7:4
`define PFM_IRQ_GP0 8
`define PFM_PIN_GP0 0
`define PFM_PIN_QTR 1
`define PFM_PIN_SIX 2
`define PFM_PIN_SER2 8
`define PFM_EXT_PINS 7:4
`define PFM_PCI_GP 15:9
`define PFM_HD_UPPER 31:16
`define PFM_QTR_LAST 3'h1
`define PFM_SIX_LAST 3'h2
`define PFM_MUL_X1 5'h01
`define PFM_MUL_X6 5'h06
`define PFM_MUL_X12 5'h0C
`define PFM_MUL_X20 5'h14
`define PFM_EMU_CODE_BSCAN 2'h0
`define PFM_EMU_CODE_EMUL 2'h3
`define PFM_HTRANS_NONSEQ 2'h2
`define PFM_HSIZE_WORD 3'h2
`endif

// File: hdl/pfm_pkg.sv
// types shared by the pin function mux
`default_nettype none
package pfm_pkg;
    // board strap levels, caught once after reset
    typedef struct packed {
        logic pci_en;
        logic cell_en;
        logic host_width;
        logic [1:0] pll_sel;
        logic [1:0] emu;
    } pfm_strap_t;

    typedef enum logic [1:0] {
        PFM_EMU_BSCAN,
        PFM_EMU_RESERVED,
        PFM_EMU_EMUL
    } pfm_emu_t;

    // one bidirectional pin group: drive value, drive enable
    typedef struct packed {
        logic [31:0] d_out;
        logic [31:0] d_oe;
    } pfm_drive32_t;

    // whole state of the block
    typedef struct packed {
        logic captured;
        pfm_strap_t strap;
        logic [15:0] gp_en;
        logic [15:0] gp_dir;
        logic [15:0] gp_out;
        logic [8:0] irq_ctl;
        logic [3:0] ext_prev;
        logic nmi_prev;
        logic [3:0] ext_pulse;
        logic nmi_pulse;
        logic [2:0] qtr_cnt;
        logic qtr_clk;
        logic [2:0] six_cnt;
        logic six_clk;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } pfm_state_t;
endpackage
`default_nettype wire

// File: test/pfm_assertions.sv
// checker for the pin function mux outputs
`default_nettype none
module pfm_check (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic nmi_pin,
    input wire logic nmi_irq,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe,
    input wire logic [4:0] pll_multiplier,
    input wire logic pci_mode,
    input wire logic host_port_16bit,
    input wire pfm_pkg::pfm_strap_t strap_pins,
    input wire logic hirq_out,
    input wire logic hirq_oe,
    input wire logic host_irq_out,
    input wire logic pci_frame_oe,
    input wire logic [7:0] cell_pin_oe,
    input wire pfm_pkg::pfm_drive32_t hd_drive,
    input wire logic [3:0] external_irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // event pulses
    nmi_rise_a:
    assert property ($rose(nmi_pin) |=> nmi_irq) else $error("nmi missed");
    nmi_fall_a:
    assert property ($fell(nmi_pin) |=> !nmi_irq [*2])
        else $error("nmi on falling edge");
    // latched modes and pin drive rules
    mode_hold_a:
    assert property ($past(hresetn) && $past(hresetn, 2) |-> $stable(pci_mode)
        && $stable(pll_multiplier) && $stable(host_port_16bit))
        else $error("mode changed without reset");
    ext_in_only_a:
    assert property (gpio_oe[7:4] == 4'h0) else $error("pins 4..7 driven");
    host_irq_a:
    assert property (!pci_mode |-> hirq_oe && hirq_out == host_irq_out)
        else $error("host irq pin not driven");
    frame_pin_a:
    assert property (pci_mode |-> hirq_oe == pci_frame_oe)
        else $error("frame pin drive wrong");
    cell_off_a:
    assert property ($past(hresetn) && !strap_pins.cell_en
        |-> cell_pin_oe == 8'h00) else $error("cell pins driven");
    upper_hd_a:
    assert property (!pci_mode && host_port_16bit
        |-> hd_drive.d_oe[31:16] == 16'h0000) else $error("upper hd driven");
    six_clock_a:
    assert property ($rose(gpio_out[2]) |-> gpio_out[2] [*3]
        ##1 !gpio_out[2] [*3]) else $error("sixth clock shape");
    // main scenarios reached
    cover property (nmi_irq);
    cover property (pci_mode && hirq_oe);
    cover property (external_irq_pin != 4'h0);
endmodule // pfm_check
bind pfm_top pfm_check i_check (.hclk, .hresetn, .nmi_pin, .nmi_irq,
    .gpio_out, .gpio_oe, .pll_multiplier, .pci_mode, .host_port_16bit,
    .strap_pins, .hirq_out, .hirq_oe, .host_irq_out, .pci_frame_oe,
    .cell_pin_oe, .hd_drive, .external_irq_pin);
`default_nettype wire

// File: test/pfm_board.sv
// strap resistors and host on the far side of the shared pins
`default_nettype none
module pfm_board (
    input wire logic hclk,
    input wire pfm_pkg::pfm_strap_t strap_set,
    input wire logic host_port_16bit,
    input wire pfm_pkg::pfm_drive32_t hd_drive,
    input wire logic [3:0] hctl_out,
    input wire logic [3:0] hctl_oe,
    input wire logic hirq_out,
    input wire logic hirq_oe,
    output pfm_pkg::pfm_strap_t strap_pins,
    output logic [31:0] hd_in,
    output logic [3:0] hctl_in,
    output logic hirq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] host_d = 32'h0, host_oe = 32'h0, last_q = 32'h0;
    logic [3:0] ctl_q = 4'h0;
    // resistors hold the strap levels
    assign strap_pins = strap_set;
    // host access fields, new each cycle
    always @(posedge hclk) begin
        ctl_q[1:0] <= 2'($urandom_range(2, 0));
        ctl_q[2] <= host_port_16bit ? 1'($urandom) : ~ctl_q[2];
        ctl_q[3] <= 1'($urandom);
        host_d <= $urandom;
        host_oe <= $urandom;
        last_q <= hd_in;
    end
    // wire level: device, else host, else floating pattern
    assign hd_in = (hd_drive.d_oe & hd_drive.d_out)
        | (~hd_drive.d_oe & host_oe & host_d)
        | (~hd_drive.d_oe & ~host_oe & ~last_q);
    assign hctl_in = (hctl_oe & hctl_out) | (~hctl_oe & ctl_q);
    assign hirq_in = hirq_oe ? hirq_out : ~ctl_q[3];
endmodule // pfm_board
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the pin function mux
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic hready, hreadyout, hresp, nmi_pin = 1'b0, hirq_in, hirq_out;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ra = 32'h0;
    logic [31:0] rb = 32'h0, hd_in, hpi_d_in, pci_ad_in, rd;
    logic [1:0] htrans = 2'h0;
    logic [15:0] gpio_ext = 16'h0, gpio_in, gpio_out, gpio_oe, en, dir, v;
    logic [3:0] hctl_in, hctl_out, hctl_oe, external_irq_pin;
    logic [4:0] pll_multiplier;
    logic [7:0] c;
    logic serial2_ext_clock_in, cpu_free_run, nmi_irq, hirq_oe;
    logic host_port_16bit, pci_mode;
    pfm_pkg::pfm_strap_t strap_set = '0, strap_pins, s;
    pfm_pkg::pfm_drive32_t hd_drive;
    pfm_pkg::pfm_emu_t emu_mode;
    int mismatches = 0, check_count = 0, n1, n2;
    // clock, random side traffic, pin resolution
    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        ra <= $urandom;
        rb <= $urandom;
    end
    assign hready = hreadyout;
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_ext);
    pfm_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .strap_pins, .nmi_pin, .gpio_in, .gpio_out, .gpio_oe,
        .gp0_irq_src(rb[20]), .serial2_ext_clock_in,
        .pci_gp_out(ra[6:0]), .pci_gp_oe(ra[13:7]), .pci_gp_in(),
        .hd_in, .hd_drive, .hpi_drive({ra, rb}), .hpi_d_in,
        .pci_ad_drive({rb, ra}), .pci_ad_in, .hctl_in, .hctl_out, .hctl_oe,
        .host_register_select(), .host_halfword_select(),
        .host_read_write_select(), .pci_ctl_out(ra[17:14]),
        .pci_ctl_oe(ra[21:18]), .pci_ctl_in(), .hirq_in, .hirq_out,
        .hirq_oe, .host_irq_out(ra[22]), .pci_frame_out(ra[23]),
        .pci_frame_oe(ra[24]), .pci_frame_in(), .cell_core_out(rb[7:0]),
        .cell_core_oe(rb[15:8]), .cell_pin_out(), .cell_pin_oe(),
        .pci_only_out(rb[17:16]), .pci_only_oe(rb[19:18]),
        .pci_only_pin_out(), .pci_only_pin_oe(), .pll_multiplier,
        .emu_mode, .cpu_free_run, .external_irq_pin, .nmi_irq,
        .host_port_16bit, .pci_mode);
    pfm_board i_board (.hclk, .strap_set, .host_port_16bit, .hd_drive,
        .hctl_out, .hctl_oe, .hirq_out, .hirq_oe, .strap_pins, .hd_in,
        .hctl_in, .hirq_in);
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single-word bus transfer, waits for hreadyout in each phase
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic do_reset(input pfm_pkg::pfm_strap_t st);
        @(posedge hclk);
        hresetn <= 1'b0;
        strap_set <= st;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask
    function automatic logic [4:0] mul_of(input logic [1:0] p);
        return p == 2'h0 ? 5'h01 : p == 2'h1 ? 5'h06 : p == 2'h2 ? 5'h0C
            : 5'h14;
    endfunction
    function automatic pfm_pkg::pfm_emu_t emu_of(input logic [1:0] e);
        return e == 2'h0 ? pfm_pkg::PFM_EMU_BSCAN : e == 2'h3
            ? pfm_pkg::PFM_EMU_EMUL : pfm_pkg::PFM_EMU_RESERVED;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        final_report();
    end
    // main sequence
    initial begin
        void'($urandom(32'hAAADDEAB));
        for (int k = 0; k < 4; k++) begin
            s = pfm_pkg::pfm_strap_t'($urandom);
            {s.cell_en, s.pci_en, s.pll_sel, s.emu} = {k[1:0], k[1:0], ~k[1:0]};
            do_reset(s);
            #1;
            chk("pll", 32'(pll_multiplier), 32'(mul_of(s.pll_sel)));
            chk("emu", 32'(emu_mode), 32'(emu_of(s.emu)));
            if (s.emu == 2'h0 || s.emu == 2'h3)
                chk("free_run", 32'(cpu_free_run), 32'h1);
            chk("pci", 32'(pci_mode), 32'(s.pci_en));
            chk("h16", 32'(host_port_16bit),
                32'(!s.pci_en && !s.host_width));
            chk("sel_in", pci_mode ? pci_ad_in : hpi_d_in, hd_in);
            chk("off_in", pci_mode ? hpi_d_in : pci_ad_in, 32'h0);
            if (!s.pci_en)
                chk("gp_hi", 32'(gpio_oe[15:9]), 32'h0);
            bus(1'b0, 8'h14, 32'h0);
            chk("strap", rd, 32'(s));
        end
        $display("test modes done");
        s = 7'h03;
        do_reset(s);
        strap_set <= 7'h3B;
        repeat (4) @(posedge hclk);
        chk("held", 32'(pll_multiplier), 32'h1);
        foreach (en[i]) begin
            if (i < 4) begin
                bus(1'b0, 8'(i * 4 + (i == 3) * 4), 32'h0);
                chk("reset_reg", rd, i == 0 ? 32'hF9 : 32'h0);
            end
        end
        n1 = 0;
        n2 = 0;
        v = gpio_out;
        repeat (24) begin
            @(posedge hclk);
            #1;
            n1 += int'(gpio_out[1] && !v[1]);
            n2 += int'(gpio_out[2] && !v[2]);
            v = gpio_out;
        end
        chk("quarter", 32'(n1), 32'd6);
        chk("sixth", 32'(n2), 32'd4);
        $display("test clocks done");
        repeat (3) begin
            en = 16'($urandom) & 16'hFFF9 | 16'h00F3;
            dir = 16'($urandom) & 16'hFF0F;
            v = 16'($urandom);
            gpio_ext <= 16'($urandom);
            bus(1'b1, 8'h00, {16'h0, en});
            bus(1'b1, 8'h04, {16'h0, dir});
            bus(1'b1, 8'h08, {16'h0, v});
            #1;
            chk("gp1_oe", 32'(gpio_oe[1]), 32'(dir[1]));
            chk("gp_oe", 32'(gpio_oe[15:9]), 32'(en[15:9] & dir[15:9]));
            if (dir[1])
                chk("gp1_out", 32'(gpio_out[1]), 32'(v[1]));
            chk("ser2", 32'(serial2_ext_clock_in),
                32'(!en[8] & gpio_ext[8]));
            bus(1'b0, 8'h0C, 32'h0);
            chk("gp_in", rd & 32'hFFFB, 32'(gpio_in & en) & 32'hFFFB);
        end
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b1, 8'h10, 32'h100);
        #1;
        chk("gp0_irq", 32'(gpio_out[0]), 32'(rb[20]));
        chk("gp0_oe", 32'(gpio_oe[0]), 32'h1);
        $display("test gpio done");
        repeat (4) begin
            c = 8'($urandom);
            bus(1'b1, 8'h10, {24'h0, c});
            gpio_ext[7:4] <= c[3:0];
            repeat (3) @(posedge hclk);
            gpio_ext[7:4] <= ~c[3:0];
            @(posedge hclk);
            #1;
            chk("ext_edge", 32'(external_irq_pin), 32'(c[7:4]));
            @(posedge hclk);
            gpio_ext[7:4] <= c[3:0];
            @(posedge hclk);
            #1;
            chk("ext_back", 32'(external_irq_pin), 32'h0);
        end
        $display("test ext irq done");
        @(posedge hclk);
        nmi_pin <= 1'b1;
        @(posedge hclk);
        #1;
        chk("nmi_rise", 32'(nmi_irq), 32'h1);
        @(posedge hclk);
        #1;
        chk("nmi_once", 32'(nmi_irq), 32'h0);
        @(posedge hclk);
        nmi_pin <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk("nmi_fall", 32'(nmi_irq), 32'h0);
        $display("test nmi done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
